// [hw/epc_cycle_engine.sv]
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// How it works
// R1: Software clears direction bit before writes
// R2: Drive selected byte onto port bus
// R3: Strobe after port data is valid
// R4: Hold IOCHRDY low while peripheral waits
// R5: Host release ends strobe, latches byte
// R6: Direction bit set releases port drivers
// R7: Read strobe with drivers already released
// R8: Peripheral drives data, then ends wait
// R9: Host read release ends strobe
// R10: Peripheral releases bus after read strobe
// R11: Outputs may change between cycles
// R12: Wait low extends host cycle
// R13: Write indication low marks a write
// R14: Peripheral interrupt passes through uninverted
// R15: Peripheral wait acknowledges each transfer
// R16: Data strobe for data, address strobe address
// R17: Active-low reset output to peripheral
// R18: Direction low unless bit set or reading
// R19: Only write indication overridable by control
// R20: Software sets direction bit before reads
// R21: Watchdog aborts cycles over 10 us
// R22: Software clears control bits before cycles
// R23: Host strobes and wait are synchronised
// R24: Reset idles with strobes deasserted
module epc_cycle_engine (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic epp_sel,
  input wire logic epp_addr_cycle,
  input wire logic iow_n,
  input wire logic ior_n,
  input wire logic [7:0] system_data_bus,
  output logic [7:0] system_data_out,
  output logic iochrdy,
  input wire logic [7:0] port_data_in,
  output logic [7:0] port_data_out,
  output logic port_data_oe,
  input wire logic periph_wait_n,
  input wire logic periph_irq_in,
  output logic irq_out,
  output epc_pkg::epc_port_s port
);
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  epc_pkg::epc_state_e state_reg;
  epc_pkg::epc_state_e state_next;
  logic [epc_pkg::CNT_W-1:0] cnt_reg;
  logic addr_cyc_reg;
  logic [7:0] ctrl_reg;
  logic tmo_reg;
  logic ap_wr_reg;
  logic [31:0] ap_addr_reg;
  logic [31:0] hrdata_reg;
  logic [7:0] port_data_reg;
  logic [7:0] rd_data_reg;
  epc_pkg::epc_port_s port_reg;
  epc_pkg::epc_port_s port_next;
  logic irq_reg;

  // Host and peripheral lines into the clock domain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= epc_pkg::SYNC_RST;
      sync_reg <= epc_pkg::SYNC_RST;
    end else begin
      meta_reg <= {iow_n, ior_n, periph_wait_n}; // R23
      sync_reg <= meta_reg; // R23
    end
  end

  wire iow_act = !sync_reg[2] && epp_sel;
  wire ior_act = !sync_reg[1] && epp_sel;
  wire wait_low = !sync_reg[0];
  wire dir_bit = ctrl_reg[epc_pkg::CTRL_DIR_BIT];
  wire ovr_bit = ctrl_reg[epc_pkg::CTRL_OVR_BIT];
  wire in_wr = state_reg == epc_pkg::ST_WSET ||
               state_reg == epc_pkg::ST_WSTB;
  wire in_rd = state_reg == epc_pkg::ST_RSET ||
               state_reg == epc_pkg::ST_RSTB;
  wire in_cyc = in_wr || in_rd;
  wire tmo_hit = cnt_reg == epc_pkg::CNT_W'(epc_pkg::TMO_CYC);

  // Cycle sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      epc_pkg::ST_IDLE: begin
        if (iow_act) begin
          state_next = epc_pkg::ST_WSET;
        end else if (ior_act) begin
          state_next = epc_pkg::ST_RSET;
        end
      end
      epc_pkg::ST_WSET: begin
        if (!iow_act) begin
          state_next = epc_pkg::ST_IDLE;
        end else begin
          state_next = epc_pkg::ST_WSTB; // R3
        end
      end
      epc_pkg::ST_WSTB: begin
        if (!iow_act) begin
          state_next = epc_pkg::ST_IDLE; // R5
        end else if (tmo_hit) begin
          state_next = epc_pkg::ST_ABORT; // R21
        end
      end
      epc_pkg::ST_RSET: begin
        if (!ior_act) begin
          state_next = epc_pkg::ST_IDLE;
        end else begin
          state_next = epc_pkg::ST_RSTB; // R7
        end
      end
      epc_pkg::ST_RSTB: begin
        if (!ior_act) begin
          state_next = epc_pkg::ST_IDLE; // R9
        end else if (tmo_hit) begin
          state_next = epc_pkg::ST_ABORT; // R21
        end
      end
      epc_pkg::ST_ABORT: begin
        if (!iow_act && !ior_act) begin
          state_next = epc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = epc_pkg::ST_IDLE;
      end
    endcase
  end

  wire nx_wstb = state_next == epc_pkg::ST_WSTB;
  wire nx_rstb = state_next == epc_pkg::ST_RSTB;
  wire nx_rd = nx_rstb || state_next == epc_pkg::ST_RSET;
  wire nx_stb = nx_wstb || nx_rstb;

  always_comb begin
    port_next.data_strobe_n = !(nx_stb && !addr_cyc_reg); // R16
    port_next.addr_strobe_n = !(nx_stb && addr_cyc_reg); // R16
    port_next.port_direction_out = dir_bit || nx_rd; // R18 R6
    port_next.write_indicate_n = dir_bit && !ovr_bit; // R1 R13 R19
    port_next.periph_reset_n = ctrl_reg[epc_pkg::CTRL_RSTN_BIT]; // R17
  end

  wire load_wr = (state_reg == epc_pkg::ST_IDLE && iow_act) ||
                 (in_wr && iow_act);
  wire load_rd = state_reg == epc_pkg::ST_RSTB && !wait_low;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= epc_pkg::ST_IDLE; // R24
      port_reg <= epc_pkg::PORT_RST; // R24
      addr_cyc_reg <= 1'b0;
      cnt_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      port_reg <= port_next; // R11
      irq_reg <= periph_irq_in; // R14
      if (state_reg == epc_pkg::ST_IDLE) begin
        addr_cyc_reg <= epp_addr_cycle;
      end
      if (in_cyc && !tmo_hit) begin
        cnt_reg <= cnt_reg + 1'b1; // R21
      end else if (!in_cyc) begin
        cnt_reg <= '0;
      end
    end
  end

  // Port and host data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_data_reg <= 8'h00;
      rd_data_reg <= 8'h00;
    end else begin
      if (load_wr) begin
        port_data_reg <= system_data_bus; // R2 R5
      end
      if (load_rd) begin
        rd_data_reg <= port_data_in;
      end
    end
  end

  assign port = port_reg;
  assign port_data_out = port_data_reg;
  assign port_data_oe = !port_reg.port_direction_out; // R6 R7
  assign system_data_out = rd_data_reg;
  assign iochrdy = !(in_cyc && wait_low); // R4 R12
  assign irq_out = irq_reg;

  // Register bus slave
  wire ap_valid = hsel && htrans[1] && hready;
  wire hit_ctrl = haddr == epc_pkg::CTRL_OFS;
  wire hit_stat = haddr == epc_pkg::STAT_OFS;
  wire dp_ctrl = ap_wr_reg && ap_addr_reg == epc_pkg::CTRL_OFS;
  wire dp_stat = ap_wr_reg && ap_addr_reg == epc_pkg::STAT_OFS;
  wire tmo_set = in_cyc && tmo_hit;
  wire tmo_clr = dp_stat && hwdata[epc_pkg::STAT_TMO_BIT];
  wire [7:0] stat_val = {5'h00, wait_low, in_cyc, tmo_reg};
  wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_reg} :
                       hit_stat ? {24'h000000, stat_val} : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_reg <= 1'b0;
      ap_addr_reg <= 32'h00000000;
      hrdata_reg <= 32'h00000000;
      ctrl_reg <= epc_pkg::CTRL_RST;
      tmo_reg <= 1'b0;
    end else begin
      ap_wr_reg <= ap_valid && hwrite;
      if (ap_valid) begin
        ap_addr_reg <= haddr;
      end
      if (ap_valid && !hwrite) begin
        hrdata_reg <= rd_mux;
      end
      if (dp_ctrl) begin
        ctrl_reg <= hwdata[7:0];
      end
      tmo_reg <= tmo_set || (tmo_reg && !tmo_clr); // R21
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  wr_strobe_one_a: assert property ( // R3
    state_reg == epc_pkg::ST_WSTB |->
      port.data_strobe_n != port.addr_strobe_n)
    else $error("write strobe missing or doubled");
  strobe_kind_a: assert property ( // R16
    state_reg == epc_pkg::ST_RSTB && addr_cyc_reg |->
      !port.addr_strobe_n && port.data_strobe_n)
    else $error("wrong strobe for address read");
  rd_released_a: assert property ( // R7
    state_reg == epc_pkg::ST_RSTB |->
      !port_data_oe && $past(!port_data_oe))
    else $error("port driven during read strobe");
  wait_holds_a: assert property ( // R4
    in_cyc && !$past(periph_wait_n, 2) |-> !iochrdy)
    else $error("iochrdy released while waiting");
  iow_end_a: assert property ( // R5
    state_reg == epc_pkg::ST_WSTB && !iow_act |=>
      port.data_strobe_n && port.addr_strobe_n &&
      port_data_out == $past(system_data_bus))
    else $error("write termination wrong");
  ior_end_a: assert property ( // R9
    state_reg == epc_pkg::ST_RSTB && !ior_act |=>
      port.data_strobe_n && port.addr_strobe_n ##1
      state_reg == epc_pkg::ST_IDLE || iow_act || ior_act)
    else $error("read termination wrong");
  watchdog_a: assert property ( // R21
    in_cyc && tmo_hit && iow_act && ior_act == 1'b0 |=>
      state_reg == epc_pkg::ST_ABORT && tmo_reg)
    else $error("watchdog did not abort");
  dir_out_a: assert property ( // R18
    port.port_direction_out |->
      $past(dir_bit) || in_rd)
    else $error("direction high without cause");
  wr_ind_a: assert property ( // R19
    $past(hresetn) |->
      port.write_indicate_n == $past(dir_bit && !ovr_bit))
    else $error("write indication mismatch");
  rst_out_a: assert property ( // R17
    $past(hresetn) |->
      port.periph_reset_n == $past(ctrl_reg[epc_pkg::CTRL_RSTN_BIT]))
    else $error("peripheral reset output wrong");
  irq_pass_a: assert property ( // R14
    $past(hresetn) |-> irq_out == $past(periph_irq_in))
    else $error("interrupt not passed through");

  write_done_c: cover property (
    state_reg == epc_pkg::ST_WSTB ##1 state_reg == epc_pkg::ST_IDLE);
  read_done_c: cover property (
    load_rd ##1 state_reg == epc_pkg::ST_IDLE);
  abort_c: cover property (state_reg == epc_pkg::ST_ABORT);
  addr_write_c: cover property (
    state_reg == epc_pkg::ST_WSTB && addr_cyc_reg);
  addr_read_c: cover property (
    state_reg == epc_pkg::ST_RSTB && addr_cyc_reg);
endmodule : epc_cycle_engine

`default_nettype wire

// [hw/epc_pkg.sv]
package epc_pkg;
  // Register map
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] STAT_OFS = 32'h0000_0004;
  localparam logic [7:0] CTRL_RST = 8'h04;
  // Control fields
  localparam int CTRL_OVR_BIT = 0;
  localparam int CTRL_AFD_BIT = 1;
  localparam int CTRL_RSTN_BIT = 2;
  localparam int CTRL_SEL_BIT = 3;
  localparam int CTRL_DIR_BIT = 5;
  // Status fields
  localparam int STAT_TMO_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_WAIT_BIT = 2;
  // Cycle watchdog
  localparam int CLK_PERIOD_NS = 8;
  localparam int TMO_US = 10;
  localparam int TMO_CYC = (TMO_US * 1000) / CLK_PERIOD_NS;
  localparam int CNT_W = 11;
  // Synchroniser reset value
  localparam logic [2:0] SYNC_RST = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WSET = 3'b001,
    ST_WSTB = 3'b010,
    ST_RSET = 3'b011,
    ST_RSTB = 3'b100,
    ST_ABORT = 3'b101
  } epc_state_e;

  typedef struct packed {
    logic write_indicate_n;
    logic data_strobe_n;
    logic addr_strobe_n;
    logic port_direction_out;
    logic periph_reset_n;
  } epc_port_s;

  localparam epc_port_s PORT_RST = 5'h1C;
endpackage : epc_pkg

// [tb/epc_periph_model.sv]
`timescale 1ns/1ns
`default_nettype none
module epc_periph_model (
  input wire logic hclk,
  input wire logic [11:0] ack_delay,
  input wire logic [7:0] rd_byte,
  input wire epc_pkg::epc_port_s port,
  input wire logic [7:0] port_data_out,
  input wire logic port_data_oe,
  output logic [7:0] port_data_in,
  output logic periph_wait_n,
  output logic [7:0] wr_byte
);
  logic [11:0] cnt;
  logic drv;
  logic [7:0] last;
  wire active = !port.data_strobe_n || !port.addr_strobe_n;
  // Released bus shows the inverse of its last level
  assign port_data_in = port_data_oe ? port_data_out :
    (drv ? rd_byte : ~last);
  initial begin
    periph_wait_n = 1'b0;
    drv = 1'b0;
    last = 8'h00;
    wr_byte = 8'h00;
    cnt = 12'h000;
  end
  always @(posedge hclk) begin
    last <= port_data_in;
    if (!port.periph_reset_n || !active) begin
      cnt <= 12'h000;
      drv <= 1'b0;
      periph_wait_n <= 1'b0;
    end else begin
      cnt <= cnt + 12'h001;
      drv <= !port_data_oe;
      periph_wait_n <= (cnt > ack_delay);
      if (port_data_oe) wr_byte <= port_data_out;
    end
  end
endmodule : epc_periph_model
`default_nettype wire

// [tb/epp17_cycle_engine_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
`define WAITC(c, n) begin for (k = 0; k < (n) && !(c); k++) @(posedge hclk); \
  if (k >= (n)) begin err_total++; report_and_stop(); end end
module epp17_cycle_engine_tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, w, adr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic epp_sel, epp_addr_cycle, iow_n, ior_n, iochrdy, port_data_oe;
  logic periph_wait_n, periph_irq_in, irq_out, irq_d;
  logic [7:0] system_data_bus, system_data_out, port_data_in, port_data_out;
  logic [7:0] rd_byte, wr_byte, b;
  logic [11:0] ack_delay;
  epc_pkg::epc_port_s port;
  int err_total, num_checks, k;
  assign hready = hreadyout;
  epc_cycle_engine dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .epp_sel(epp_sel), .epp_addr_cycle(epp_addr_cycle),
    .iow_n(iow_n), .ior_n(ior_n), .system_data_bus(system_data_bus),
    .system_data_out(system_data_out), .iochrdy(iochrdy),
    .port_data_in(port_data_in), .port_data_out(port_data_out),
    .port_data_oe(port_data_oe), .periph_wait_n(periph_wait_n),
    .periph_irq_in(periph_irq_in), .irq_out(irq_out), .port(port));
  epc_periph_model peer_u (.hclk(hclk), .ack_delay(ack_delay),
    .rd_byte(rd_byte), .port(port), .port_data_out(port_data_out),
    .port_data_oe(port_data_oe), .port_data_in(port_data_in),
    .periph_wait_n(periph_wait_n), .wr_byte(wr_byte));
  function automatic logic [1:0] exp_stb(input logic a);
    return a ? 2'b10 : 2'b01;
  endfunction : exp_stb
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic edge_rdy();
    @(posedge hclk);
    `WAITC(hready === 1'b1, 50)
  endtask : edge_rdy
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    haddr <= a;
    edge_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask : ahb
  task automatic host(input logic wr, input logic a, input logic [7:0] v);
    epp_addr_cycle <= a;
    system_data_bus <= v;
    epp_sel <= 1'b1;
    if (wr) iow_n <= 1'b0;
    else ior_n <= 1'b0;
    `WAITC((port.data_strobe_n & port.addr_strobe_n) === 1'b0, 20)
    `CHK({port.data_strobe_n, port.addr_strobe_n}, exp_stb(a))
    `CHK(iochrdy, 1'b0)
    `CHK(port_data_oe, wr)
    `CHK(port.write_indicate_n, !wr)
    `CHK(port.port_direction_out, !wr)
    if (wr) `CHK(port_data_out, v)
    `WAITC(iochrdy === 1'b1, 40)
    `CHK(port.data_strobe_n & port.addr_strobe_n, 1'b0)
    iow_n <= 1'b1;
    ior_n <= 1'b1;
    `WAITC((port.data_strobe_n & port.addr_strobe_n) === 1'b1, 10)
    if (wr) `CHK({wr_byte, port_data_out}, {v, v})
    else `CHK(system_data_out, rd_byte)
    epp_sel <= 1'b0;
    @(posedge hclk);
  endtask : host
  always @(posedge hclk) begin
    if (hresetn) `CHK(irq_out, irq_d)
    irq_d <= periph_irq_in;
    periph_irq_in <= hresetn ? 1'($urandom) : 1'b0;
  end
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {epp_sel, epp_addr_cycle, system_data_bus, ack_delay, rd_byte} = '0;
    {iow_n, ior_n, periph_irq_in, irq_d} = 4'hC;
    err_total = 0;
    num_checks = 0;
    k = $urandom(80);
    repeat (4) @(posedge hclk);
    `CHK(port, epc_pkg::PORT_RST)
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK(port.periph_reset_n, 1'b1)
    `CHK(port.write_indicate_n, 1'b0)
    ahb(1'b1, epc_pkg::CTRL_OFS, 32'h0000_0025);
    ahb(1'b0, epc_pkg::CTRL_OFS, 32'h0);
    `CHK(rd[7:0], 8'h25)
    `CHK({port.write_indicate_n, port.port_direction_out}, 2'b01)
    ahb(1'b0, 32'h0000_0040, 32'h0);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 16; i++) begin
      b = 8'($urandom);
      w = 1'($urandom);
      adr = 1'($urandom);
      ack_delay <= (i < 2) ? 12'h000 : 12'($urandom_range(9));
      rd_byte <= 8'($urandom);
      ahb(1'b1, epc_pkg::CTRL_OFS, w ? 32'h04 : 32'h24);
      host(w, adr, b);
    end
    ack_delay <= 12'hFFF;
    ahb(1'b1, epc_pkg::CTRL_OFS, 32'h0000_0004);
    epp_addr_cycle <= 1'b0;
    epp_sel <= 1'b1;
    iow_n <= 1'b0;
    `WAITC(port.data_strobe_n === 1'b0, 20)
    repeat (1200) @(posedge hclk);
    `CHK(port.data_strobe_n, 1'b0)
    `WAITC(port.data_strobe_n === 1'b1, 100)
    `CHK(iochrdy, 1'b1)
    iow_n <= 1'b1;
    ahb(1'b0, epc_pkg::STAT_OFS, 32'h0);
    `CHK(rd[0], 1'b1)
    ahb(1'b1, epc_pkg::STAT_OFS, 32'h1);
    ahb(1'b0, epc_pkg::STAT_OFS, 32'h0);
    `CHK(rd[0], 1'b0)
    report_and_stop();
  end
endmodule : epp17_cycle_engine_tb
`default_nettype wire
